//--- rtl/dmt_map.vh
/*
 * Register map, field positions and reset values of the dual 8-bit match timer.
 * Assumes a byte-wide register port with 16-bit byte addresses.
 */
// Contract
// - Match of count and compare raises interrupt
// - Timers 0 and 1 join as 16-bit
// - Count source: slow clock or fast oscillator
// - Source divisible by 2 to 64, or undivided
// - Auto-reload or one-shot mode per timer
// - Compare 8 bits, resets FF, zero stores 01
// - Counter is 8-bit up-counter, resets zero
// - Any counter write clears that counter
// - Cascaded: either counter write clears both
// - Cascaded: timer 1 on overflow, no t0 irq
// - Divide codes 0-6 select 1..64, 7 undivided
// - Start bit one starts; cascaded timer1 start ignored
// - Source 0 slow, 1 fast; t0 governs cascade
`ifndef DMT_MAP_VH
`define DMT_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DMT_OFF_CMP0 16'hF300
`define DMT_OFF_CMP1 16'hF301
`define DMT_OFF_CNT0 16'hF310
`define DMT_OFF_CNT1 16'hF311
`define DMT_OFF_CTL0 16'hF320
`define DMT_OFF_CTL1 16'hF321
`define DMT_OFF_START 16'hF330
`define DMT_OFF_STOP 16'hF332
`define DMT_OFF_RUN 16'hF334
`define DMT_OFF_IRQ_STAT 16'hF340
`define DMT_OFF_IRQ_MASK 16'hF341

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DMT_CTL_OST 7
`define DMT_CTL_CAS 6
`define DMT_CTL_DIV_HI 5
`define DMT_CTL_DIV_LO 3
`define DMT_CTL_CS 0
`define DMT_CTL_WMASK 8'hF9

// ----------------------------------------
// Reset and special values
// ----------------------------------------
`define DMT_CMP_RST 8'hFF
`define DMT_CMP_MIN 8'h01
`define DMT_CNT_RST 8'h00
`define DMT_CTL_RST 8'h00
`define DMT_DIV_OFF 3'h7

`endif

//--- rtl/dmt_sync.v
/*
 * Two-flop synchroniser with rising-edge pulse for the count clock pins.
 * Assumes the pins toggle much slower than clk (at most clk/4).
 */
`timescale 1ns/1ps
`default_nettype none

module dmt_sync #(
	parameter W = 2 // Number of pins
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Asynchronous pins
	input wire [W-1:0] pin,
	// One-cycle pulse per rising edge
	output wire [W-1:0] rise
);

	reg [W-1:0] meta_r; // First stage, only read by second
	reg [W-1:0] sync_r; // Second stage
	reg [W-1:0] last_r; // Delayed copy for edge detect

	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
			last_r <= {W{1'b0}};
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// Edge only seen after two flops
	assign rise = sync_r & ~last_r;

endmodule // dmt_sync
`default_nettype wire

//--- rtl/dmt_presc.v
/*
 * Power-of-two prescaler for one timer's count ticks.
 * Assumes tick is a one-cycle pulse in the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module dmt_presc #(
	parameter DW = 6 // Prescaler depth, divide up to 2**DW
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Hold at zero while the timer is idle
	input wire clr,
	// Undivided tick and divide code
	input wire tick,
	input wire [2:0] sel,
	// Divided tick
	output wire out
);

	reg [DW-1:0] cnt_r; // Free prescale count
	reg [DW-1:0] mask; // Bits that must be all ones

	// ----------------------------------------
	// Divide code to mask
	// ----------------------------------------
	always @* begin
		mask = {DW{1'b0}};
		case (sel)
			3'h0: mask = {DW{1'b0}};
			3'h1: mask = 6'h01;
			3'h2: mask = 6'h03;
			3'h3: mask = 6'h07;
			3'h4: mask = 6'h0F;
			3'h5: mask = 6'h1F;
			3'h6: mask = 6'h3F;
			default: mask = {DW{1'b0}};
		endcase
	end

	// ----------------------------------------
	// Prescale counter, restarts with the timer
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst || clr) begin
			cnt_r <= {DW{1'b0}};
		end else if (tick) begin
			cnt_r <= cnt_r + {{(DW-1){1'b0}}, 1'b1};
		end
	end

	// Pass every 2**n-th tick for codes 0 to 6, every tick for code 7
	assign out = tick & ((cnt_r & mask) == mask);

endmodule // dmt_presc
`default_nettype wire

//--- rtl/dmt_top.v
/*
 * Dual 8-bit match timer with 16-bit cascade, prescalers and interrupts.
 * Assumes a byte register port on clk; count clock pins are asynchronous
 * and much slower than clk, so each rising edge is seen as one tick.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dmt_map.vh"

module dmt_top (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Register port
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Count clock pins
	input wire slow_clock,
	input wire fast_osc_clock,
	// Interrupts
	output reg [1:0] match_irq,
	output reg irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] cmp0_r, cmp0_nxt; // Timer 0 compare
	reg [7:0] cmp1_r, cmp1_nxt; // Timer 1 compare
	reg [7:0] cnt0_r, cnt0_nxt; // Timer 0 counter
	reg [7:0] cnt1_r, cnt1_nxt; // Timer 1 counter
	reg [7:0] ctl0_r, ctl0_nxt; // Timer 0 control
	reg [7:0] ctl1_r, ctl1_nxt; // Timer 1 control
	reg run0_r, run0_nxt; // Timer 0 running flag
	reg run1_r, run1_nxt; // Timer 1 running flag
	reg [1:0] stat_r, stat_nxt; // Sticky match status
	reg [1:0] mask_r, mask_nxt; // Interrupt enable
	reg [1:0] hit; // Match events this cycle
	reg [7:0] rd_mux; // Read data source
	reg [7:0] inc0; // Timer 0 plus one
	reg [7:0] inc1; // Timer 1 plus one
	reg [15:0] inc16; // Cascaded pair plus one

	// ----------------------------------------
	// Decoded control fields
	// ----------------------------------------
	wire casc; // Cascade select
	wire ost0; // Timer 0 one-shot
	wire ost1; // Timer 1 one-shot
	wire cs0; // Timer 0 source
	wire cs1; // Timer 1 source, overridden in cascade
	wire [2:0] div0; // Timer 0 divide code
	wire [2:0] div1; // Timer 1 divide code

	assign casc = ctl0_r[`DMT_CTL_CAS];
	assign ost0 = ctl0_r[`DMT_CTL_OST];
	assign ost1 = ctl1_r[`DMT_CTL_OST];
	assign cs0 = ctl0_r[`DMT_CTL_CS];
	assign cs1 = casc ? cs0 : ctl1_r[`DMT_CTL_CS];
	assign div0 = ctl0_r[`DMT_CTL_DIV_HI:`DMT_CTL_DIV_LO];
	assign div1 = ctl1_r[`DMT_CTL_DIV_HI:`DMT_CTL_DIV_LO];

	// ----------------------------------------
	// Count clock ticks
	// ----------------------------------------
	wire [1:0] src_rise; // Bit 0 slow, bit 1 fast
	wire src0_tick; // Selected tick, timer 0
	wire src1_tick; // Selected tick, timer 1
	wire p0_tick; // Divided tick, timer 0
	wire p1_tick; // Divided tick, timer 1

	// Pins are foreign to clk, so they pass the synchroniser first
	dmt_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.pin({fast_osc_clock, slow_clock}),
		.rise(src_rise)
	);

	// Zero picks the slow clock, one the fast oscillator
	assign src0_tick = cs0 ? src_rise[1] : src_rise[0];
	assign src1_tick = cs1 ? src_rise[1] : src_rise[0];

	// Prescaler idles at zero so each start begins a full period
	dmt_presc #(
		.DW(6)
	) u_presc0 (
		.clk(clk),
		.srst(srst),
		.clr(~run0_r),
		.tick(src0_tick),
		.sel(div0),
		.out(p0_tick)
	);

	dmt_presc #(
		.DW(6)
	) u_presc1 (
		.clk(clk),
		.srst(srst),
		.clr(~run1_r),
		.tick(src1_tick),
		.sel(div1),
		.out(p1_tick)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Counting first, then bus writes, so a write in the same cycle
	// as a tick has the final word on the counter.
	always @* begin
		cmp0_nxt = cmp0_r;
		cmp1_nxt = cmp1_r;
		cnt0_nxt = cnt0_r;
		cnt1_nxt = cnt1_r;
		ctl0_nxt = ctl0_r;
		ctl1_nxt = ctl1_r;
		run0_nxt = run0_r;
		run1_nxt = run1_r;
		mask_nxt = mask_r;
		hit = 2'h0;
		inc0 = cnt0_r + 8'h01;
		inc1 = cnt1_r + 8'h01;
		inc16 = {cnt1_r, cnt0_r} + 16'h0001;

		// Timer 0, or the cascaded pair
		if (run0_r && p0_tick) begin
			if (casc) begin
				// Low byte carry ripples into timer 1
				if (inc16 == {cmp1_r, cmp0_r}) begin
					cnt0_nxt = 8'h00;
					cnt1_nxt = 8'h00;
					hit[1] = 1'b1;
					if (ost0) begin
						run0_nxt = 1'b0;
						run1_nxt = 1'b0;
					end
				end else begin
					cnt0_nxt = inc16[7:0];
					cnt1_nxt = inc16[15:8];
				end
			end else begin
				if (inc0 == cmp0_r) begin
					cnt0_nxt = 8'h00;
					hit[0] = 1'b1;
					if (ost0) begin
						run0_nxt = 1'b0;
					end
				end else begin
					cnt0_nxt = inc0;
				end
			end
		end

		// Timer 1 on its own
		if (!casc && run1_r && p1_tick) begin
			if (inc1 == cmp1_r) begin
				cnt1_nxt = 8'h00;
				hit[1] = 1'b1;
				if (ost1) begin
					run1_nxt = 1'b0;
				end
			end else begin
				cnt1_nxt = inc1;
			end
		end

		// Bus writes
		if (wr) begin
			case (addr)
				`DMT_OFF_CMP0: begin
					// Zero would only match on the wrap from FF, so it is stored as one
					cmp0_nxt = (wdata == 8'h00) ? `DMT_CMP_MIN : wdata;
				end
				`DMT_OFF_CMP1: begin
					cmp1_nxt = (wdata == 8'h00) ? `DMT_CMP_MIN : wdata;
				end
				`DMT_OFF_CNT0, `DMT_OFF_CNT1: begin
					// Data is ignored; the write only clears
					if (casc) begin
						cnt0_nxt = `DMT_CNT_RST;
						cnt1_nxt = `DMT_CNT_RST;
					end else if (addr == `DMT_OFF_CNT0) begin
						cnt0_nxt = `DMT_CNT_RST;
					end else begin
						cnt1_nxt = `DMT_CNT_RST;
					end
				end
				`DMT_OFF_CTL0: begin
					ctl0_nxt = wdata & `DMT_CTL_WMASK;
				end
				`DMT_OFF_CTL1: begin
					ctl1_nxt = wdata & `DMT_CTL_WMASK;
				end
				`DMT_OFF_START: begin
					// A zero bit keeps the current state
					if (wdata[0]) begin
						run0_nxt = 1'b1;
						if (casc) begin
							run1_nxt = 1'b1;
						end
					end
					if (wdata[1] && !casc) begin
						run1_nxt = 1'b1;
					end
				end
				`DMT_OFF_STOP: begin
					if (wdata[0]) begin
						run0_nxt = 1'b0;
						if (casc) begin
							run1_nxt = 1'b0;
						end
					end
					// Timer 1 stop ignored while cascaded
					if (wdata[1] && !casc) begin
						run1_nxt = 1'b0;
					end
				end
				`DMT_OFF_IRQ_MASK: begin
					mask_nxt = wdata[1:0];
				end
				default: begin
					cmp0_nxt = cmp0_nxt;
				end
			endcase
		end

		// Sticky status: write one clears, a new match wins
		stat_nxt = stat_r;
		if (wr && addr == `DMT_OFF_IRQ_STAT) begin
			stat_nxt = stat_r & ~wdata[1:0];
		end
		stat_nxt = stat_nxt | hit;
	end

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	// Counters are sampled on clk, so a read never sees a half-updated
	// value; software still owes the double-read on slower parts.
	always @* begin
		rd_mux = 8'h00;
		case (addr)
			`DMT_OFF_CMP0: rd_mux = cmp0_r;
			`DMT_OFF_CMP1: rd_mux = cmp1_r;
			`DMT_OFF_CNT0: rd_mux = cnt0_r;
			`DMT_OFF_CNT1: rd_mux = cnt1_r;
			`DMT_OFF_CTL0: rd_mux = ctl0_r;
			`DMT_OFF_CTL1: rd_mux = ctl1_r;
			`DMT_OFF_RUN: rd_mux = {6'h00, run1_r, run0_r};
			`DMT_OFF_IRQ_STAT: rd_mux = {6'h00, stat_r};
			`DMT_OFF_IRQ_MASK: rd_mux = {6'h00, mask_r};
			default: rd_mux = 8'h00; // Start, stop, unmapped
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			cmp0_r <= `DMT_CMP_RST;
			cmp1_r <= `DMT_CMP_RST;
			cnt0_r <= `DMT_CNT_RST;
			cnt1_r <= `DMT_CNT_RST;
			ctl0_r <= `DMT_CTL_RST;
			ctl1_r <= `DMT_CTL_RST;
			run0_r <= 1'b0;
			run1_r <= 1'b0;
			stat_r <= 2'h0;
			mask_r <= 2'h0;
		end else begin
			cmp0_r <= cmp0_nxt;
			cmp1_r <= cmp1_nxt;
			cnt0_r <= cnt0_nxt;
			cnt1_r <= cnt1_nxt;
			ctl0_r <= ctl0_nxt;
			ctl1_r <= ctl1_nxt;
			run0_r <= run0_nxt;
			run1_r <= run1_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
		end
	end

	// ----------------------------------------
	// Output flops
	// ----------------------------------------
	// Read data only in the cycle after the strobe, zero otherwise
	always @(posedge clk) begin
		if (srst) begin
			rdata <= 8'h00;
			match_irq <= 2'h0;
			irq <= 1'b0;
		end else begin
			rdata <= rd ? rd_mux : 8'h00;
			match_irq <= hit;
			irq <= |(stat_r & mask_r);
		end
	end

endmodule // dmt_top
`default_nettype wire

//--- sim/dmt_top_assertions.sv
/* Port checker for dmt_top.
   Bound to each dmt_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dmt_chk (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Register port
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	// Pins and interrupts
	input wire slow_clock,
	input wire fast_osc_clock,
	input wire [1:0] match_irq,
	input wire irq
);
	// ----
	// Helpers
	// ----
	reg [1:0] pins_r; // Last pin levels
	reg [3:0] quiet_r; // Cycles with no pin change
	wire ev = wr | (|match_irq); // Causes of an irq rise
	// Quiet counter saturates; a tick needs about three edges to land
	always @(posedge clk) begin
		pins_r <= {slow_clock, fast_osc_clock};
		if (srst || pins_r != {slow_clock, fast_osc_clock})
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ----
	// Assertions
	// ----
	rst_quiet_a: assert property (disable iff (1'b0)
		srst |=> rdata == 8'h00 && match_irq == 2'b00 && !irq) else $error("outputs live in reset");
	rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata set without read");
	rd_zero_a: assert property (rd && (addr == 16'hF330 || addr == 16'hF332) |=> rdata == 8'h00)
		else $error("start or stop read not zero");
	m0_pulse_a: assert property (match_irq[0] |=> !match_irq[0])
		else $error("match 0 longer than a cycle");
	m1_pulse_a: assert property (match_irq[1] |=> !match_irq[1])
		else $error("match 1 longer than a cycle");
	no_tick_a: assert property (quiet_r >= 4'hA |-> match_irq == 2'b00)
		else $error("match without a tick");
	irq_fall_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
		else $error("irq fell without a write");
	irq_rise_a: assert property ($rose(irq) |-> ev || $past(ev) || $past(ev, 2))
		else $error("irq rose without a cause");
endmodule // dmt_chk
bind dmt_top dmt_chk u_dmt_chk (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .slow_clock(slow_clock),
	.fast_osc_clock(fast_osc_clock), .match_irq(match_irq), .irq(irq));
`default_nettype wire

//--- sim/tb.sv
/* Self-checking bench for dmt_top.
   Drives the register port and both count pins itself. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----
	// Signals
	// ----
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [1:0] pin = 2'b00; // Bit 1 slow pin, bit 0 fast pin
	logic [7:0] rdata;
	logic [1:0] match_irq;
	logic irq;
	int n_fail = 0;
	int samples_checked = 0;
	logic [7:0] ra [12] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h20, 8'h21, 8'h30, 8'h32,
		8'h34, 8'h40, 8'h41, 8'hFF}; // Last one unmapped
	always #12.5 clk = ~clk;
	logic [7:0] m0_seen = 8'h00; // Timer 0 match pulses seen
	logic [7:0] m1_seen = 8'h00; // Timer 1 or cascade match pulses seen
	// Count match pulses while they stand; skip reset, outputs are unknown before it
	always @(posedge clk) begin
		if (!srst) begin
			m0_seen <= m0_seen + {7'h00, match_irq[0]};
			m1_seen <= m1_seen + {7'h00, match_irq[1]};
		end
	end
	dmt_top u_dmt_top (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .slow_clock(pin[1]), .fast_osc_clock(pin[0]),
		.match_irq(match_irq), .irq(irq));
	// ----
	// Tasks
	// ----
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Offsets are the low byte of the map
	task wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= {8'hF3, a};
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= {8'hF3, a};
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Three cycles high, three low, so the synchroniser sees each one
	task tk(input logic [1:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			pin <= m;
			repeat (3) @(posedge clk);
			pin <= 2'b00;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
	task done(input string s);
		$display("test %s ended", s);
	endtask
	task results;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			rdc(ra[i], i < 2 ? 8'hFF : 8'h00);
		end
		wrr(8'h00, 8'h00);
		rdc(8'h00, 8'h01);
		done("reset");
		wrr(8'h00, 8'h03);
		wrr(8'h41, 8'h03);
		wrr(8'h30, 8'h01);
		rdc(8'h34, 8'h01);
		tk(2'b10, 2);
		rdc(8'h10, 8'h02);
		// Running slow-clocked counter: a second read must agree
		rdc(8'h10, 8'h02);
		tk(2'b01, 2);
		rdc(8'h10, 8'h02);
		tk(2'b10, 1);
		rdc(8'h10, 8'h00);
		rdc(8'h40, 8'h01);
		chk({7'h00, irq}, 8'h01);
		rdc(8'h34, 8'h01);
		wrr(8'h40, 8'h01);
		rdc(8'h40, 8'h00);
		chk({7'h00, irq}, 8'h00);
		tk(2'b10, 1);
		wrr(8'h10, 8'h55);
		rdc(8'h10, 8'h00);
		// Masked event still sets status
		wrr(8'h41, 8'h00);
		tk(2'b10, 3);
		rdc(8'h40, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wrr(8'h40, 8'h01);
		wrr(8'h32, 8'h01);
		rdc(8'h34, 8'h00);
		chk(m0_seen, 8'h02);
		done("auto");
		wrr(8'h00, 8'h02);
		wrr(8'h20, 8'h80);
		wrr(8'h30, 8'h01);
		tk(2'b10, 2);
		rdc(8'h34, 8'h00);
		tk(2'b10, 1);
		rdc(8'h10, 8'h00);
		chk(m0_seen, 8'h03);
		wrr(8'h40, 8'h01);
		wrr(8'h00, 8'hFF);
		done("oneshot");
		for (int n = 0; n < 8; n++) begin
			wrr(8'h10, 8'h00);
			wrr(8'h20, {2'b00, n[2:0], 3'b001});
			wrr(8'h30, 8'h01);
			tk(2'b01, 64);
			// Fast-clocked counter read while running; clk is never the slow clock
			rdc(8'h10, n == 7 ? 8'h40 : 8'h40 >> n);
			wrr(8'h32, 8'h01);
		end
		done("divide");
		wrr(8'h20, 8'h40);
		wrr(8'h10, 8'h00);
		wrr(8'h00, 8'h02);
		wrr(8'h01, 8'h01);
		wrr(8'h41, 8'h03);
		wrr(8'h30, 8'h01);
		rdc(8'h34, 8'h03);
		tk(2'b10, 257);
		rdc(8'h10, 8'h01);
		rdc(8'h11, 8'h01);
		tk(2'b10, 1);
		rdc(8'h40, 8'h02);
		rdc(8'h11, 8'h00);
		tk(2'b10, 3);
		wrr(8'h11, 8'hAA);
		rdc(8'h10, 8'h00);
		wrr(8'h32, 8'h01);
		wrr(8'h30, 8'h02);
		rdc(8'h34, 8'h00);
		chk(m0_seen, 8'h03);
		chk(m1_seen, 8'h01);
		done("cascade");
		// Timer 1 alone: one-shot on the fast pin
		wrr(8'h20, 8'h00);
		wrr(8'h01, 8'h02);
		wrr(8'h21, 8'h81);
		wrr(8'h30, 8'h02);
		rdc(8'h34, 8'h02);
		tk(2'b10, 2);
		rdc(8'h11, 8'h00);
		tk(2'b01, 1);
		rdc(8'h11, 8'h01);
		tk(2'b01, 1);
		rdc(8'h34, 8'h00);
		chk(m1_seen, 8'h02);
		done("timer1");
		// Reset with both timers stopped and the cascade event still pending
		chk({7'h00, irq}, 8'h01);
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rdc(8'h00, 8'hFF);
		rdc(8'h01, 8'hFF);
		rdc(8'h40, 8'h00);
		chk({7'h00, irq}, 8'h00);
		done("midreset");
		results;
	end
	// Run needs under 10000 cycles
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		results;
	end
endmodule // tb
`default_nettype wire
